// [inc/tosm_defines.svh]
// constants of the torque-off safety monitor: offsets, fields, counts
// assumes a 40 MHz system clock and a 32-bit axi4-lite register bus
// Summary of operation
// - show blocked-run indication whenever torque-off input is de-energised
// - an active trip takes display priority over the blocked-run indication
// - relay one opens on torque-off when its function select equals 13
// - relay two opens on torque-off when its function select equals 13
// - a fault in either internal channel raises fault code 29
// - output goes non-torque-producing within 1 ms of de-energising
// - monitoring status output changes within 20 ms of de-energising
// - channel fault shown and health output not-healthy within 20 ms
// - torque-off can never be disabled by mode or setting
// - start commands are ignored while torque-off inputs are de-energised
// - leaving torque-off needs faults reset and inputs re-energised
// - with inputs energised, a start command starts the motor normally
`ifndef TOSM_DEFINES_SVH
`define TOSM_DEFINES_SVH
`define TOSM_CLK_HZ 40000000
`define TOSM_TORQUE_OFF_US 1000
`define TOSM_STATUS_US 20000
`define TOSM_TORQUE_OFF_CYC ((`TOSM_CLK_HZ / 1000000) * `TOSM_TORQUE_OFF_US)
`define TOSM_STATUS_CYC ((`TOSM_CLK_HZ / 1000000) * `TOSM_STATUS_US)
`define TOSM_MISMATCH_CYC 200000
`define TOSM_RELAY_STO_FUNC 8'h0D
`define TOSM_FAULT_CODE 8'h1D
`define TOSM_OFF_CTRL 12'h000
`define TOSM_OFF_CFG 12'h004
`define TOSM_OFF_STAT 12'h008
`define TOSM_OFF_IRQ_STAT 12'h00C
`define TOSM_OFF_IRQ_MASK 12'h010
`define TOSM_OFF_TRIP 12'h014
`define TOSM_CTRL_START 0
`define TOSM_CTRL_STOP 1
`define TOSM_CTRL_RESET 2
`define TOSM_CTRL_TRIP 3
`define TOSM_IRQ_STO_ON 0
`define TOSM_IRQ_STO_OFF 1
`define TOSM_IRQ_FAULT 2
`define TOSM_IRQ_BLOCKED 3
`define TOSM_CFG_RESET 32'h0000_0000
`define TOSM_MASK_RESET 4'h0
`endif

// [inc/tosm_pkg.sv]
// types of the torque-off safety monitor
// assumes tosm_defines.svh supplies the numeric constants
package tosm_pkg;
  typedef enum logic [1:0] {
    TOSM_ST_STANDBY = 2'b00,
    TOSM_ST_RUN = 2'b01,
    TOSM_ST_SAFE_OFF = 2'b10,
    TOSM_ST_FAULT = 2'b11
  } tosm_state_t;
  typedef enum logic [1:0] {
    TOSM_DISP_STOP = 2'b00,
    TOSM_DISP_RUN = 2'b01,
    TOSM_DISP_INHIBIT = 2'b10,
    TOSM_DISP_TRIP = 2'b11
  } tosm_disp_t;
endpackage

// [inc/tosm_chan_if.sv]
// channel bundle between the monitor and its channel checker
// assumes one clock domain shared by both modules
`timescale 1ns/1ps
`default_nettype none
interface tosm_chan_if;
  logic ch_a;
  logic ch_b;
  logic active;
  logic fault;
  modport checker_mp(input ch_a, input ch_b, output active, output fault);
  modport monitor_mp(output ch_a, output ch_b, input active, input fault);
endinterface
`default_nettype wire

// [rtl/tosm_chan_check.sv]
// dual-channel input synchroniser and discrepancy checker
// assumes raw channel levels arrive asynchronously; high means energised
`timescale 1ns/1ps
`default_nettype none
`include "tosm_defines.svh"
module tosm_chan_check import tosm_pkg::*; #(
  parameter int MISMATCH_CYC = `TOSM_MISMATCH_CYC
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic fault_clr, // one-cycle fault clear request
  tosm_chan_if.checker_mp ch // channel bundle
);
  // the discrepancy counter is 24 bits wide and needs at least two counts
  if (MISMATCH_CYC < 2 || MISMATCH_CYC > 16777215) begin : g_bad_cyc
    $error("mismatch count out of range");
  end
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  logic active_q;
  logic fault_q;
  logic fault_d;
  wire logic mismatch;
  wire logic limit_hit;
  // two-stage synchronisers, first stage read only by second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
    end else begin
      meta_q <= {ch.ch_b, ch.ch_a};
      sync_q <= meta_q;
    end
  end
  // channels disagreeing too long means an internal channel fault
  assign mismatch = sync_q[0] ^ sync_q[1];
  assign limit_hit = (cnt_q == 24'(MISMATCH_CYC - 1));
  assign cnt_d = mismatch ? (limit_hit ? cnt_q : cnt_q + 24'h1) : 24'h0;
  assign fault_d = (mismatch && limit_hit) | (fault_q & ~fault_clr);
  // either channel low means torque-off active
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 24'h0;
      active_q <= 1'b1;
      fault_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      active_q <= ~(sync_q[0] & sync_q[1]);
      fault_q <= fault_d;
    end
  end
  assign ch.active = active_q;
  assign ch.fault = fault_q;
endmodule
`default_nettype wire

// [rtl/tosm_monitor.sv]
// torque-off safety monitor with axi4-lite registers
// assumes aclk at 40 MHz, inputs synchronous except the two channel pins
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tosm_defines.svh"
module tosm_monitor import tosm_pkg::*; #(
  parameter int MISMATCH_CYC = `TOSM_MISMATCH_CYC
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic sto_ch_a, // torque-off channel a, high energised
  input wire logic sto_ch_b, // torque-off channel b, high energised
  input wire logic start_cmd, // start from the start source
  input wire logic stop_cmd, // stop from the start source
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic gate_enable, // power stage enable, low = no torque
  output logic relay_one_closed, // relay one coil, high closed
  output logic relay_two_closed, // relay two coil, high closed
  output logic sto_status, // monitoring status, high when active
  output logic health_ok, // health output, high when healthy
  output logic [1:0] disp_mode, // display selection, tosm_disp_t
  output logic [7:0] disp_code, // trip code shown when tripped
  output logic irq // level interrupt
);
  // refuse response budgets shorter than the channel pipeline
  if (`TOSM_TORQUE_OFF_CYC < 3 || `TOSM_STATUS_CYC < 3) begin : g_bad_budget
    $error("response budgets too short for the pipeline");
  end
  tosm_chan_if chan();
  assign chan.ch_a = sto_ch_a;
  assign chan.ch_b = sto_ch_b;
  logic fault_clr;
  tosm_chan_check #(.MISMATCH_CYC(MISMATCH_CYC)) u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .fault_clr(fault_clr),
    .ch(chan)
  );
  // register state
  logic [7:0] r1_func_q;
  logic [7:0] r2_func_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [7:0] trip_code_q;
  logic trip_q;
  tosm_state_t st_q;
  tosm_state_t st_d;
  logic sto_prev_q;
  // bus handshake state
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  // write path: accept address and data in either order
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire logic sel_ctrl = (aw_addr_q == `TOSM_OFF_CTRL);
  wire logic sel_cfg = (aw_addr_q == `TOSM_OFF_CFG);
  wire logic sel_mask = (aw_addr_q == `TOSM_OFF_IRQ_MASK);
  wire logic sel_trip = (aw_addr_q == `TOSM_OFF_TRIP);
  wire logic wr_ok = sel_ctrl | sel_cfg | sel_mask | sel_trip |
    (aw_addr_q == `TOSM_OFF_STAT) | (aw_addr_q == `TOSM_OFF_IRQ_STAT);
  wire logic ctrl_wr = wr_fire & sel_ctrl & w_strb_q[0];
  wire logic sw_start = ctrl_wr & w_data_q[`TOSM_CTRL_START];
  wire logic sw_stop = ctrl_wr & w_data_q[`TOSM_CTRL_STOP];
  wire logic sw_reset = ctrl_wr & w_data_q[`TOSM_CTRL_RESET];
  wire logic sw_trip = ctrl_wr & w_data_q[`TOSM_CTRL_TRIP];
  // read path
  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  wire logic rd_stat = (s_axi_araddr == `TOSM_OFF_IRQ_STAT);
  logic [31:0] rd_word;
  logic rd_ok;
  // merged byte write helper
  function automatic logic [7:0] byte_upd(input logic [7:0] old,
      input logic [31:0] data, input logic [3:0] strb, input int lane);
    byte_upd = strb[lane] ? data[lane*8 +: 8] : old;
  endfunction
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == `TOSM_OFF_CTRL) begin
      rd_word = 32'h0000_0000;
    end else if (s_axi_araddr == `TOSM_OFF_CFG) begin
      rd_word = {16'h0000, r2_func_q, r1_func_q};
    end else if (s_axi_araddr == `TOSM_OFF_STAT) begin
      rd_word = {24'h0000_00, chan.fault, trip_q, chan.active, 3'h0,
        st_q};
    end else if (s_axi_araddr == `TOSM_OFF_IRQ_STAT) begin
      rd_word = {28'h000_0000, irq_stat_q};
    end else if (s_axi_araddr == `TOSM_OFF_IRQ_MASK) begin
      rd_word = {28'h000_0000, irq_mask_q};
    end else if (s_axi_araddr == `TOSM_OFF_TRIP) begin
      rd_word = {24'h0000_00, trip_code_q};
    end else begin
      rd_ok = 1'b0;
    end
  end
  // address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end
  // ready lines, write response and read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_awready <= ~aw_held_q & ~aw_take & ~s_axi_awready;
      s_axi_wready <= ~w_held_q & ~w_take & ~s_axi_wready;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // configuration, mask and external trip registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r1_func_q <= 8'(`TOSM_CFG_RESET);
      r2_func_q <= 8'(`TOSM_CFG_RESET);
      irq_mask_q <= `TOSM_MASK_RESET;
      trip_code_q <= 8'h00;
    end else if (wr_fire) begin
      if (sel_cfg) begin
        r1_func_q <= byte_upd(r1_func_q, w_data_q, w_strb_q, 0);
        r2_func_q <= byte_upd(r2_func_q, w_data_q, w_strb_q, 1);
      end
      if (sel_mask && w_strb_q[0]) begin
        irq_mask_q <= w_data_q[3:0];
      end
      if (sel_trip && w_strb_q[0]) begin
        trip_code_q <= w_data_q[7:0];
      end
    end
  end
  // start requests from pin or software
  wire logic start_req = start_cmd | sw_start;
  wire logic stop_req = stop_cmd | sw_stop;
  wire logic sto_on = chan.active;
  wire logic ch_fault = chan.fault;
  // trip latch: external trip, channel fault; reset clears when cause gone
  assign fault_clr = sw_reset;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_q <= 1'b0;
    end else if ((ch_fault && !sw_reset) || sw_trip) begin
      trip_q <= 1'b1;
    end else if (sw_reset) begin
      trip_q <= 1'b0;
    end
  end
  // run state machine; torque-off overrides every mode
  always_comb begin
    st_d = st_q;
    case (st_q)
      TOSM_ST_STANDBY: begin
        if (trip_q) begin
          st_d = TOSM_ST_FAULT;
        end else if (sto_on) begin
          st_d = TOSM_ST_SAFE_OFF;
        end else if (start_req) begin
          st_d = TOSM_ST_RUN;
        end
      end
      TOSM_ST_RUN: begin
        if (trip_q) begin
          st_d = TOSM_ST_FAULT;
        end else if (sto_on) begin
          st_d = TOSM_ST_SAFE_OFF;
        end else if (stop_req) begin
          st_d = TOSM_ST_STANDBY;
        end
      end
      TOSM_ST_SAFE_OFF: begin
        if (trip_q) begin
          st_d = TOSM_ST_FAULT;
        end else if (!sto_on) begin
          st_d = TOSM_ST_STANDBY;
        end
      end
      TOSM_ST_FAULT: begin
        if (!trip_q && !sto_on) begin
          st_d = TOSM_ST_STANDBY;
        end else if (!trip_q) begin
          st_d = TOSM_ST_SAFE_OFF;
        end
      end
      default: begin
        st_d = TOSM_ST_FAULT;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= TOSM_ST_SAFE_OFF;
    end else begin
      st_q <= st_d;
    end
  end
  // display selection: trip beats inhibit beats run/stop
  wire tosm_disp_t disp_d = trip_q ? TOSM_DISP_TRIP :
    sto_on ? TOSM_DISP_INHIBIT :
    (st_q == TOSM_ST_RUN) ? TOSM_DISP_RUN : TOSM_DISP_STOP;
  wire logic [7:0] code_d = ch_fault ? `TOSM_FAULT_CODE : trip_code_q;
  wire logic r1_sto = (r1_func_q == `TOSM_RELAY_STO_FUNC);
  wire logic r2_sto = (r2_func_q == `TOSM_RELAY_STO_FUNC);
  // pin outputs, each a few cycles after the channel pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_enable <= 1'b0;
      relay_one_closed <= 1'b0;
      relay_two_closed <= 1'b0;
      sto_status <= 1'b1;
      health_ok <= 1'b1;
      disp_mode <= TOSM_DISP_INHIBIT;
      disp_code <= 8'h00;
      sto_prev_q <= 1'b1;
    end else begin
      gate_enable <= (st_d == TOSM_ST_RUN) & ~sto_on;
      relay_one_closed <= ~(r1_sto & sto_on);
      relay_two_closed <= ~(r2_sto & sto_on);
      sto_status <= sto_on;
      health_ok <= ~trip_q & ~ch_fault;
      disp_mode <= disp_d;
      disp_code <= trip_q ? code_d : 8'h00;
      sto_prev_q <= sto_on;
    end
  end
  // sticky events, cleared by reading the interrupt status register; set wins
  wire logic [3:0] ev = {sto_on & start_req, ch_fault,
    sto_prev_q & ~sto_on, ~sto_prev_q & sto_on};
  wire logic stat_rd = ar_take & rd_stat;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= ev | (irq_stat_q & {4{~stat_rd}});
      irq <= |((ev | (irq_stat_q & {4{~stat_rd}})) & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

// [verification/tosm_props.sv]
// checker on the torque-off monitor ports
// assumes one aclk domain and binding onto tosm_monitor
`timescale 1ns/1ps
`default_nettype none
`include "tosm_defines.svh"
module tosm_props import tosm_pkg::*; #(
  parameter int MISMATCH_CYC = `TOSM_MISMATCH_CYC
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // reset, active low
  input wire logic sto_ch_a, // channel a
  input wire logic sto_ch_b, // channel b
  input wire logic gate_enable, // power stage enable
  input wire logic relay_one_closed, // relay one
  input wire logic relay_two_closed, // relay two
  input wire logic sto_status, // torque-off status
  input wire logic health_ok, // health output
  input wire logic [1:0] disp_mode, // display selection
  input wire logic [7:0] disp_code // trip code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int mis_q;
  // counts cycles during which the channels disagree
  always_ff @(posedge aclk) begin
    if (!aresetn || sto_ch_a == sto_ch_b) mis_q <= 0;
    else if (mis_q < 100000) mis_q <= mis_q + 1;
  end
  // timing, display and output relations
  gate_off_a:
    assert property (($fell(sto_ch_a) || $fell(sto_ch_b)) |->
      ##[1:5] !gate_enable) else $error("gate stays on");
  status_on_a:
    assert property (($fell(sto_ch_a) || $fell(sto_ch_b)) |->
      ##[1:5] sto_status) else $error("status late");
  sto_gate_a:
    assert property (sto_status |-> !gate_enable)
    else $error("torque with status active");
  inhibit_show_a:
    assert property (sto_status |->
      disp_mode inside {TOSM_DISP_INHIBIT, TOSM_DISP_TRIP})
    else $error("inhibit not shown");
  code_idle_a:
    assert property (disp_mode != TOSM_DISP_TRIP |-> disp_code == 8'h00)
    else $error("code without trip");
  chan_fault_a:
    assert property (mis_q == MISMATCH_CYC + 8 |->
      disp_mode == TOSM_DISP_TRIP && disp_code == `TOSM_FAULT_CODE)
    else $error("channel fault missing");
  health_low_a:
    assert property ($rose(disp_mode == TOSM_DISP_TRIP) |->
      ##[0:4] !health_ok) else $error("health stays ok");
  relay_rest_a:
    assert property (!sto_status && !$past(sto_status, 2) |->
      relay_one_closed && relay_two_closed)
    else $error("relay open without torque-off");
  run_cause_a:
    assert property ($rose(gate_enable) |-> !sto_status && health_ok)
    else $error("run while blocked");
endmodule
`default_nettype wire

// [verification/tosm_relay_model.sv]
// stand-in for the external safety relay feeding both channels
// assumes requests change just after a rising aclk edge
`timescale 1ns/1ps
`default_nettype none
module tosm_relay_model (
  input wire logic aclk, // system clock
  input wire logic [1:0] open_sel, // bit0 opens a, bit1 opens b
  output logic sto_ch_a, // channel a, high energised
  output logic sto_ch_b // channel b, high energised
);
  // contacts start closed so the drive powers up energised
  initial begin
    sto_ch_a = 1'h1;
    sto_ch_b = 1'h1;
  end
  // each contact follows its request one edge later
  always @(posedge aclk) begin
    sto_ch_a <= !open_sel[0];
    sto_ch_b <= !open_sel[1];
  end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench of the torque-off monitor
// assumes tosm_relay_model drives the channels, axi4-lite by tasks
`timescale 1ns/1ps
`default_nettype none
`include "tosm_defines.svh"
module testbench import tosm_pkg::*;;
  localparam int MC = 16;
  logic aclk = 1'h0, aresetn = 1'h0, start_cmd = 1'h0, stop_cmd = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, disp_mode, osel = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, gate_enable, relay_one_closed, relay_two_closed;
  logic sto_status, health_ok, irq;
  logic [7:0] disp_code;
  logic [65:0] e;
  logic [65:0] q[$];
  wire logic sto_ch_a, sto_ch_b;
  int n_fail = 0, check_count = 0, seed = 32'hF62A8370;
  // clock and a watchdog
  initial forever #12.5 aclk = ~aclk;
  initial begin
    repeat (20000) @(posedge aclk);
    lost();
  end
  tosm_relay_model far (.aclk, .open_sel(osel), .sto_ch_a, .sto_ch_b);
  tosm_monitor #(.MISMATCH_CYC(MC)) dut (.aclk, .aresetn, .sto_ch_a,
    .sto_ch_b, .start_cmd, .stop_cmd, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_enable,
    .relay_one_closed, .relay_two_closed, .sto_status, .health_ok,
    .disp_mode, .disp_code, .irq);
  // compare, report and close
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic lost();
    n_fail++;
    complete_run();
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // bus master cycles, a hang ends the run
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic ad, dd;
    ad = 1'h0;
    dd = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (ad && dd && s_axi_bvalid) begin
        r = s_axi_bresp;
        return;
      end
      if (s_axi_awready && !ad) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready && !dd) begin
        dd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    lost();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
      input logic [33:0] x);
    logic ad;
    ad = 1'h0;
    q.push_back({m, x});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (ad && s_axi_rvalid) return;
      if (s_axi_arready && !ad) begin
        ad = 1'h1;
        s_axi_arvalid <= 1'h0;
      end
    end
    lost();
  endtask
  // read answers are judged against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'h1 && q.size() > 0) begin
      e = q.pop_front();
      chk({s_axi_rresp, s_axi_rdata & e[65:34]}, e[33:0]);
    end
  end
  // start by the port or by the control register
  task automatic go(input int p);
    logic [1:0] r;
    if (p != 0) begin
      start_cmd <= 1'h1;
      wt(1);
      start_cmd <= 1'h0;
    end else begin
      wr(`TOSM_OFF_CTRL, 32'h1, r);
    end
  endtask
  task automatic wgate();
    for (int i = 0; i < 40 && gate_enable !== 1'h1; i++) @(posedge aclk);
    if (gate_enable !== 1'h1) lost();
  endtask
  // main sequence
  initial begin
    logic [1:0] r;
    logic [7:0] v;
    wt(6);
    aresetn <= 1'h1;
    wt(9);
    chk(sto_status, 1'h0);
    rd(`TOSM_OFF_CFG, 32'hFFFFFFFF, {2'h0, `TOSM_CFG_RESET});
    rd(`TOSM_OFF_IRQ_MASK, 32'hF, 34'h0);
    rd(12'h100, 32'h0, {2'h2, 32'h0});
    wr(12'h104, 32'h1, r);
    chk(r, 2'h2);
    go(0);
    wgate();
    stop_cmd <= 1'h1;
    wt(1);
    stop_cmd <= 1'h0;
    wt(4);
    chk(disp_mode, TOSM_DISP_STOP);
    for (int k = 0; k < 2; k++) begin
      v = 8'h0D;
      while (v == 8'h0D) v = 8'($random(seed));
      wr(`TOSM_OFF_CFG, k ? {16'h0, v, 8'h0D} : {16'h0, 8'h0D, v}, r);
      wr(`TOSM_OFF_IRQ_MASK, k ? 32'h0 : 32'h8, r);
      go(k);
      wgate();
      wt(1);
      chk(disp_mode, TOSM_DISP_RUN);
      rd(`TOSM_OFF_IRQ_STAT, 32'h0, 34'h0);
      osel <= k ? 2'h2 : 2'h1;
      wt(7);
      chk(gate_enable, 1'h0);
      chk(sto_status, 1'h1);
      chk(disp_mode, TOSM_DISP_INHIBIT);
      chk(relay_one_closed, k == 0);
      chk(relay_two_closed, k == 1);
      osel <= 2'h3;
      go(1 - k);
      wt(3);
      chk(gate_enable, 1'h0);
      chk(disp_mode, TOSM_DISP_INHIBIT);
      chk(irq, k == 0);
      rd(`TOSM_OFF_IRQ_STAT, 32'hF, 34'h9);
      wt(2);
      chk(irq, 1'h0);
      osel <= 2'h0;
      wt(7);
      chk(sto_status, 1'h0);
      chk(gate_enable, 1'h0);
    end
    osel <= 2'h1;
    wt(MC + 14);
    chk(disp_mode, TOSM_DISP_TRIP);
    chk(disp_code, `TOSM_FAULT_CODE);
    chk(health_ok, 1'h0);
    rd(`TOSM_OFF_STAT, 32'h80, {2'h0, 32'h80});
    rd(`TOSM_OFF_IRQ_STAT, 32'h4, 34'h4);
    osel <= 2'h0;
    wt(7);
    chk(disp_mode, TOSM_DISP_TRIP);
    wr(`TOSM_OFF_CTRL, 32'h4, r);
    wt(4);
    chk(health_ok, 1'h1);
    chk(disp_mode, TOSM_DISP_STOP);
    v = 8'($random(seed)) | 8'h01;
    wr(`TOSM_OFF_TRIP, {24'h0, v}, r);
    wr(`TOSM_OFF_CTRL, 32'h8, r);
    osel <= 2'h3;
    wt(7);
    chk(disp_mode, TOSM_DISP_TRIP);
    chk(disp_code, v);
    wr(`TOSM_OFF_CTRL, 32'h4, r);
    wt(4);
    chk(disp_mode, TOSM_DISP_INHIBIT);
    complete_run();
  end
endmodule
bind tosm_monitor tosm_props #(.MISMATCH_CYC(MISMATCH_CYC)) props (.aclk,
  .aresetn, .sto_ch_a, .sto_ch_b, .gate_enable, .relay_one_closed,
  .relay_two_closed, .sto_status, .health_ok, .disp_mode, .disp_code);
`default_nettype wire
